// File: verilog/gpio_defines.svh
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// Register indices (byte address = index)
`define GPIO_ADDR_DATA   8'hE0
`define GPIO_ADDR_CFG_A  8'hF0
`define GPIO_ADDR_CFG_B  8'hF1
`define GPIO_ADDR_CFG_C  8'hF2
`define GPIO_ADDR_INLAT  8'hE8

// Reset values
`define GPIO_RST_DATA    8'hFF
`define GPIO_RST_CFG     8'h00

`endif

// File: verilog/gpio_pkg.sv
package gpio_pkg;
  // Pin role decoded from config bits {c,b,a}
  typedef enum logic [2:0] {
    GPIO_BID_WPU,
    GPIO_BID_OD,
    GPIO_OUT_PP,
    GPIO_OUT_OD,
    GPIO_IN_CMOS,
    GPIO_IN_TTL,
    GPIO_AF_PP,
    GPIO_AF_OD
  } gpio_mode_type;
endpackage : gpio_pkg

// File: verilog/gpio_pin_bit.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.svh"

// One pin: decodes its role and drives the pad from the slave latch or, in alternate modes, from the alternate output
module gpio_pin_bit (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic cfg_a_i,
  input  wire logic cfg_b_i,
  input  wire logic cfg_c_i,
  input  wire logic analog_hw_i,
  input  wire logic pullup_hw_i,
  input  wire logic slave_i,
  input  wire logic af_out_i,
  output logic      pad_o,
  output logic      pad_oe_n_o,
  output logic      pullup_o,
  output logic      analog_sel_o
);

  gpio_pkg::gpio_mode_type mode;
  logic                    next_pad;
  logic                    next_oe_n;

  assign mode = gpio_pkg::gpio_mode_type'({cfg_c_i, cfg_b_i, cfg_a_i} == 3'h0 ? 3'h0 :
               {cfg_c_i, cfg_b_i, cfg_a_i} == 3'h4 ? 3'h1 :
               {cfg_c_i, cfg_b_i, cfg_a_i} == 3'h2 ? 3'h2 :
               {cfg_c_i, cfg_b_i, cfg_a_i} == 3'h6 ? 3'h3 :
               {cfg_c_i, cfg_b_i, cfg_a_i} == 3'h1 ? 3'h4 :
               {cfg_c_i, cfg_b_i, cfg_a_i} == 3'h5 ? 3'h5 :
               {cfg_c_i, cfg_b_i, cfg_a_i} == 3'h3 ? 3'h6 : 3'h7);

  // Driver decode; low enable means the pad is driven
  always_comb
  begin
    next_pad  = 1'b1;
    next_oe_n = 1'b1;
    case (mode)
      gpio_pkg::GPIO_BID_WPU,
      gpio_pkg::GPIO_BID_OD:
      begin
        next_pad  = 1'b0;
        next_oe_n = slave_i;
      end
      gpio_pkg::GPIO_OUT_PP:
      begin
        next_pad  = slave_i;
        next_oe_n = 1'b0;
      end
      gpio_pkg::GPIO_OUT_OD:
      begin
        next_pad  = 1'b0;
        next_oe_n = slave_i;
      end
      gpio_pkg::GPIO_AF_PP:
      begin
        next_pad  = af_out_i;
        next_oe_n = 1'b0;
      end
      gpio_pkg::GPIO_AF_OD:
      begin
        next_pad  = 1'b0;
        next_oe_n = analog_hw_i | af_out_i;
      end
      default:
      begin
        next_pad  = 1'b1;
        next_oe_n = 1'b1;
      end
    endcase
  end

  // Pad flops; ce low freezes pins (halt holds only the slave latch feeding them)
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pad_o        <= 1'b0;
      pad_oe_n_o   <= 1'b1;
      pullup_o     <= 1'b0;
      analog_sel_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pad_o        <= next_pad;
      pad_oe_n_o   <= next_oe_n;
      pullup_o     <= (mode == gpio_pkg::GPIO_BID_WPU) & pullup_hw_i;
      analog_sel_o <= (mode == gpio_pkg::GPIO_AF_OD) & analog_hw_i;
    end
  end

endmodule : gpio_pin_bit
`default_nettype wire

// File: verilog/gpio_port.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.svh"

module gpio_port #(
  parameter int WIDTH  = 8,
  parameter int NUM_AF = 2
) (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    instr_start_i,
  input  wire logic                    instr_end_i,
  input  wire logic                    halt_i,
  input  wire logic [7:0]              addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [7:0]              rdata_o,
  input  wire logic [WIDTH-1:0]        pad_i,
  output logic      [WIDTH-1:0]        pad_o,
  output logic      [WIDTH-1:0]        pad_oe_n_o,
  output logic      [WIDTH-1:0]        pullup_o,
  output logic      [WIDTH-1:0]        analog_sel_o,
  input  wire logic [WIDTH-1:0]        analog_hw_i,
  input  wire logic [WIDTH-1:0]        pullup_hw_i,
  input  wire logic [NUM_AF*WIDTH-1:0] af_out_i,
  input  wire logic [NUM_AF*WIDTH-1:0] af_conn_i,
  output logic      [WIDTH-1:0]        af_in_o,
  input  wire logic                    clk_out_src_i,
  output logic                         clk_out_o
);

  logic [WIDTH-1:0] master;
  logic [WIDTH-1:0] slave;
  logic [WIDTH-1:0] in_latch;
  logic [WIDTH-1:0] cfg_a;
  logic [WIDTH-1:0] cfg_b;
  logic [WIDTH-1:0] cfg_c;
  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] sync3;
  logic [WIDTH-1:0] pin_lvl;
  logic [WIDTH-1:0] af_and;
  logic [WIDTH-1:0] af_any;
  logic [WIDTH-1:0] out_mode;
  logic [WIDTH-1:0] samp_mode;
  logic [WIDTH-1:0] af_mode;

  // Role decode shared by several processes
  function automatic logic is_mode(input logic a, input logic b, input logic c,
                                   input logic [2:0] code);
    is_mode = ({c, b, a} == code);
  endfunction : is_mode

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1   <= '0;
      sync2   <= '0;
      sync3   <= '0;
      pin_lvl <= '0;
    end
    else if (ce_i)
    begin
      sync1 <= pad_i;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_lvl <= (sync2 & sync3) | (pin_lvl & (sync2 | sync3));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-bit role flags
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      out_mode[i]  = is_mode(cfg_a[i], cfg_b[i], cfg_c[i], 3'h2) |
                     is_mode(cfg_a[i], cfg_b[i], cfg_c[i], 3'h6);
      af_mode[i]   = is_mode(cfg_a[i], cfg_b[i], cfg_c[i], 3'h3) |
                     is_mode(cfg_a[i], cfg_b[i], cfg_c[i], 3'h7);
      samp_mode[i] = ~out_mode[i];
    end
  end

  // Alternate outputs are ANDed; unconnected sources count as one
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      af_and[i] = 1'b1;
      af_any[i] = 1'b0;
      for (int k = 0; k < NUM_AF; k++)
      begin
        af_and[i] = af_and[i] & (af_out_i[k*WIDTH+i] | ~af_conn_i[k*WIDTH+i]);
        af_any[i] = af_any[i] | af_conn_i[k*WIDTH+i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers; all bits clear selects bidir weak pull-up
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_a <= `GPIO_RST_CFG;
      cfg_b <= `GPIO_RST_CFG;
      cfg_c <= `GPIO_RST_CFG;
    end
    else if (ce_i && wr_i)
    begin
      if (addr_i == `GPIO_ADDR_CFG_A)
        cfg_a <= wdata_i[WIDTH-1:0];
      if (addr_i == `GPIO_ADDR_CFG_B)
        cfg_b <= wdata_i[WIDTH-1:0];
      if (addr_i == `GPIO_ADDR_CFG_C)
        cfg_c <= wdata_i[WIDTH-1:0];
    end
  end

  // Master latch loaded from the data bus in every mode
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      master <= `GPIO_RST_DATA;
    else if (ce_i && wr_i && addr_i == `GPIO_ADDR_DATA)
      master <= wdata_i[WIDTH-1:0];
  end

  // Slave latch: master at end of instruction, else holds its value.
  // Halt holds it so the pins stay put.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      slave <= `GPIO_RST_DATA;
    else if (ce_i && !halt_i && instr_end_i)
      slave <= master;
  end

  // Input latch: pin at start in input/bidir/alt, master at end in output
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      in_latch <= `GPIO_RST_DATA;
    else if (ce_i && !halt_i)
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (samp_mode[i] && instr_start_i)
          in_latch[i] <= pin_lvl[i];
        else if (out_mode[i] && instr_end_i)
          in_latch[i] <= master[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register reads, answer one cycle later; unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rdata_o <= 8'h00;
    else if (ce_i)
    begin
      rdata_o <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          `GPIO_ADDR_DATA:  rdata_o <= 8'(in_latch);
          `GPIO_ADDR_CFG_A: rdata_o <= 8'(cfg_a);
          `GPIO_ADDR_CFG_B: rdata_o <= 8'(cfg_b);
          `GPIO_ADDR_CFG_C: rdata_o <= 8'(cfg_c);
          `GPIO_ADDR_INLAT: rdata_o <= 8'(master);
          default:          rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Alternate inputs see the pin buffer itself, including own driven level.
  // The synchronised level is used so peripherals never see metastability.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      af_in_o <= '1;
    else if (ce_i)
      af_in_o <= pin_lvl;
  end

  // Clock output runs in wait, stops during halt
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      clk_out_o <= 1'b0;
    else if (ce_i && !halt_i)
      clk_out_o <= clk_out_src_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers, one per bit; same logic serves memory ports used as I/O
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_pin
    gpio_pin_bit u_pin (
      .clk_i        (clk_i),
      .sys_rst_i    (sys_rst_i),
      .ce_i         (ce_i),
      .cfg_a_i      (cfg_a[g]),
      .cfg_b_i      (cfg_b[g]),
      .cfg_c_i      (cfg_c[g]),
      .analog_hw_i  (analog_hw_i[g]),
      .pullup_hw_i  (pullup_hw_i[g]),
      .slave_i      (slave[g]),
      .af_out_i     (af_and[g] & (af_any[g] | 1'b1)),
      .pad_o        (pad_o[g]),
      .pad_oe_n_o   (pad_oe_n_o[g]),
      .pullup_o     (pullup_o[g]),
      .analog_sel_o (analog_sel_o[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  master_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && wr_i && addr_i == `GPIO_ADDR_DATA) |=> master == $past(wdata_i[WIDTH-1:0]))
    else $error("master latch not loaded");

  read_timing_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && rd_i && addr_i == `GPIO_ADDR_DATA) |=> rdata_o == 8'($past(in_latch)))
    else $error("port read wrong");

  slave_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !halt_i && instr_end_i) |=> slave == $past(master))
    else $error("slave latch not updated");

  halt_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && halt_i) |=> (slave == $past(slave) && clk_out_o == $past(clk_out_o)))
    else $error("halt changed state");

  out_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && is_mode(cfg_a[0], cfg_b[0], cfg_c[0], 3'h2)) |=> !pad_oe_n_o[0])
    else $error("push-pull output not driven");

  in_tristate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && is_mode(cfg_a[0], cfg_b[0], cfg_c[0], 3'h1)) |=> pad_oe_n_o[0])
    else $error("input not tristated");

  reset_data_a: assert property (@(posedge clk_i)
    sys_rst_i |=> (master == `GPIO_RST_DATA && cfg_a == '0 && cfg_b == '0 && cfg_c == '0))
    else $error("reset state wrong");

  wait_clock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !halt_i) |=> clk_out_o == $past(clk_out_src_i))
    else $error("clock output stalled");

  //////////////////////////////////////////////////////////////////////////////
  // Latch and pin checks; bit 0 stands for every bit since the logic is per bit
  // Alternate inputs must track the settled pin, never a latch
  af_in_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i |=> af_in_o == $past(pin_lvl))
    else $error("alternate input not following pin");

  in_sample_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !halt_i && instr_start_i && samp_mode[0]) |=> in_latch[0] == $past(pin_lvl[0]))
    else $error("input latch missed pin sample");

  out_copy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !halt_i && instr_end_i && out_mode[0]) |=> in_latch[0] == $past(master[0]))
    else $error("input latch missed master copy");

  analog_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && af_mode[0] && cfg_c[0] && analog_hw_i[0]) |=> pad_oe_n_o[0])
    else $error("converter pin driven");

  af_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && af_mode[0] && !cfg_c[0]) |=> (!pad_oe_n_o[0] && pad_o[0] == $past(af_and[0])))
    else $error("alternate push-pull level wrong");

  bid_pullup_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && is_mode(cfg_a[0], cfg_b[0], cfg_c[0], 3'h0)) |=> pullup_o[0] == $past(pullup_hw_i[0]))
    else $error("weak pull-up wrong");

  // Read data stand one cycle only, so an idle cycle must show zero
  read_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !rd_i) |=> rdata_o == 8'h00)
    else $error("read data lingered");

  halt_latch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && halt_i) |=> in_latch == $past(in_latch))
    else $error("halt changed input latch");

endmodule : gpio_port
`default_nettype wire

// File: sim/gpio_pin_env.sv
`timescale 1ns/1ps
`default_nettype none

// Pad wires: the design's driver, an outside driver, then the weak pull-up
module gpio_pin_env (
  input  wire logic       clk_i,
  input  wire logic [7:0] dut_pad_i,
  input  wire logic [7:0] dut_oe_n_i,
  input  wire logic [7:0] dut_pullup_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic      [7:0] pin_o
);
  logic [7:0] flt;

  // A pin nobody holds toggles, so a sampled float never looks stable
  always @(posedge clk_i)
  begin
    flt <= ~flt;
  end

  // Active-low enable wins over the outside driver
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!dut_oe_n_i[i])
        pin_o[i] = dut_pad_i[i];
      else if (ext_en_i[i])
        pin_o[i] = ext_val_i[i];
      else if (dut_pullup_i[i])
        pin_o[i] = 1'b1;
      else
        pin_o[i] = flt[i];
    end
  end

  initial flt = 8'h55;
endmodule : gpio_pin_env
`default_nettype wire

// File: sim/tb_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defines.svh"

module tb_gpio_port;
  logic        clk_i, sys_rst_i, ce_i, st, en, halt;
  logic [7:0]  addr, wdata, rdata, pad_i, pad_o, oe_n, pu, asel, ahw, puhw;
  logic [7:0]  ext_en, ext_val, af_in;
  logic [15:0] af_out, af_conn;
  logic        wr, rd, csrc, cout, v;
  int          err_count, tests_run, cyc;

  gpio_port gpio_port_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .instr_start_i(st), .instr_end_i(en), .halt_i(halt), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_n_o(oe_n), .pullup_o(pu), .analog_sel_o(asel),
    .analog_hw_i(ahw), .pullup_hw_i(puhw), .af_out_i(af_out),
    .af_conn_i(af_conn), .af_in_o(af_in), .clk_out_src_i(csrc), .clk_out_o(cout));

  gpio_pin_env gpio_pin_env_i (.clk_i(clk_i), .dut_pad_i(pad_o), .dut_oe_n_i(oe_n),
    .dut_pullup_i(pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pad_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Free-running source for the clock output pin
  always @(posedge clk_i)
  begin
    csrc <= ~csrc;
    cyc  <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd <= 1'b1; addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask : rd_chk

  // Config code is {c,b,a}; each byte sets that bit for all eight pins
  task automatic mode(input logic [2:0] m);
    wr_reg(`GPIO_ADDR_CFG_A, {8{m[0]}});
    wr_reg(`GPIO_ADDR_CFG_B, {8{m[1]}});
    wr_reg(`GPIO_ADDR_CFG_C, {8{m[2]}});
  endtask : mode

  // Let the pin synchroniser settle, then one start pulse and one end pulse
  task automatic instr();
    tick(4);
    @(posedge clk_i);
    st <= 1'b1;
    @(posedge clk_i);
    st <= 1'b0; en <= 1'b1;
    @(posedge clk_i);
    en <= 1'b0;
    tick(3);
  endtask : instr

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {sys_rst_i, ce_i, st, en, halt, wr, rd, csrc, cyc} = '0;
    {addr, wdata, ext_en, ext_val, af_out, af_conn} = '0;
    ahw = 8'h01; puhw = 8'hFF; err_count = 0; tests_run = 0;
    sys_rst_i = 1'b1; ce_i = 1'b1;
    tick(5);
    sys_rst_i <= 1'b0;
    tick(2);
    rd_chk("rst data", `GPIO_ADDR_DATA, `GPIO_RST_DATA);
    rd_chk("rst cfg", `GPIO_ADDR_CFG_A, `GPIO_RST_CFG);
    chk("rst oe_n", 8'hFF, oe_n);
    chk("rst pullup", 8'hFF, pu);
    $display("reset test done");

    mode(3'b010);
    wr_reg(`GPIO_ADDR_DATA, 8'hA5);
    rd_chk("master", `GPIO_ADDR_INLAT, 8'hA5);
    instr();
    chk("pp pad", 8'hA5, pad_o);
    chk("pp oe_n", 8'h00, oe_n);
    rd_chk("pp inlat", `GPIO_ADDR_DATA, 8'hA5);
    mode(3'b110);
    instr();
    chk("od oe_n", 8'hA5, oe_n);
    $display("output test done");

    // Outside world pulls bits 3 and 2 low under a released bidir port
    mode(3'b000);
    ext_en <= 8'h0C; ext_val <= 8'h00;
    wr_reg(`GPIO_ADDR_DATA, 8'h0F);
    // Start samples the pin before end moves master out, so take two
    instr();
    instr();
    chk("bid oe_n", 8'h0F, oe_n);
    chk("bid pad", 8'h00, pad_o);
    rd_chk("bid read", `GPIO_ADDR_DATA, 8'h03);
    rd_chk("bid master", `GPIO_ADDR_INLAT, 8'h0F);
    $display("bidir test done");

    mode(3'b001);
    ext_en <= 8'hFF; ext_val <= 8'h5A;
    instr();
    chk("in oe_n", 8'hFF, oe_n);
    rd_chk("in read", `GPIO_ADDR_DATA, 8'h5A);
    chk("af in", 8'h5A, af_in);
    $display("input test done");

    // Two alternate sources share the pins; an unconnected one counts as 1
    ext_en <= 8'h00;
    mode(3'b011);
    af_out <= 16'h3CF0; af_conn <= 16'hFFFF;
    instr();
    chk("af and", 8'h30, pad_o);
    chk("af oe_n", 8'h00, oe_n);
    chk("af loop", 8'h30, af_in);
    af_conn <= 16'h0000;
    instr();
    chk("af none pp", 8'hFF, pad_o);
    mode(3'b111);
    af_out <= 16'h0000; af_conn <= 16'hFFFF;
    instr();
    chk("af od oe_n", 8'h01, oe_n);
    chk("analog", 8'h01, asel);
    af_conn <= 16'h0000;
    instr();
    chk("af none od", 8'hFF, oe_n);
    $display("alternate test done");

    // Halt freezes pins and the clock output; wait keeps the clock running
    mode(3'b010);
    wr_reg(`GPIO_ADDR_DATA, 8'h11);
    instr();
    v = cout;
    tick(1);
    chk("wait clk", {7'h00, ~v}, {7'h00, cout});
    halt <= 1'b1;
    wr_reg(`GPIO_ADDR_DATA, 8'h22);
    instr();
    chk("halt pad", 8'h11, pad_o);
    v = cout;
    tick(1);
    chk("halt clk", {7'h00, v}, {7'h00, cout});
    halt <= 1'b0;
    instr();
    chk("resume pad", 8'h22, pad_o);
    $display("power mode test done");
    tally_and_finish();
  end
endmodule : tb_gpio_port
`default_nettype wire
